// File: core/adc_seq_defs.vh
// Constants for the queued converter sequencer and result table
// What this block does
// (R1) End of queue sets completion flag, interrupts
// (R2) Queue 1 trigger aborts and suspends queue 2
// (R3) Queue 2 resumes at subqueue start or aborted
// (R4) Disabling a queue aborts, converter stays powered
// (R5) Mode change aborts, restarts at first entry
// (R6) Stop mode bit aborts conversion in progress
// (R7) Debug freeze halts after conversion, then continues
// (R8) 64 by 10-bit results written at CONVERSION_COMMAND_WORD index
// (R9) Unimplemented result bits read zero, ignore writes
// (R10) Address alias selects one of three formats
// (R11) Signed format inverts top bit, offset binary
// (R12) Table writes always taken right-justified
// (R13) Done pointers update only on result write
// (R14) Pause holds live pointer until new trigger
// (R15) Status field codes 0, 8 and 4
// (R16) Queue ends on channel 63, base, table end
// (R17) Pause sets pause flag, may interrupt
// (R18) 64-entry 10-bit CONVERSION_COMMAND_WORD table, software only
// (R19) Three aliases index same result storage
// (R20) Aborted conversion writes no result
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH
`define A_CTRL1 12'h000
`define A_CTRL2 12'h004
`define A_MCR 12'h008
`define A_STAT 12'h00c
`define RG_CTRL 4'h0
`define RG_CCW 4'h1
`define RG_RIGHT 4'h2
`define RG_SIGNED 4'h3
`define RG_LEFT 4'h4
`define F_RIGHT 2'h0
`define F_SIGNED 2'h1
`define F_LEFT 2'h2
`define M_DIS 2'h0
`define M_SW 2'h1
`define M_EXT 2'h2
`define M_CONT 2'h3
`define B_IEC 2
`define B_IEP 3
`define B_GO 4
`define B_RESUME 5
`define B_STOP 0
`define B_FRZ 1
`define CH_EOQ 6'h3f
`define TBL_END 7'h40
`define QS_ACT 2'h2
`define QS_PAU 2'h1
`define QS_SUS 2'h3
`define QS_OFF 2'h0
`endif

// File: core/result_align.v
// Routes a 10-bit result onto a 16-bit word in one of three alignments
module result_align (
  input wire [9:0] raw,
  input wire [1:0] fmt,
  output reg [15:0] aligned
);
  `include "adc_seq_defs.vh"

  always @* begin
    case (fmt)
      `F_SIGNED: aligned = {~raw[9], raw[8:0], 6'h00}; // [R10] [R11]
      `F_LEFT: aligned = {raw, 6'h00}; // [R10]
      default: aligned = {6'h00, raw}; // [R10] [R9]
    endcase
  end
endmodule

// File: core/adc_queue_sequencer.v
// Queue sequencer, command and result tables, APB register slave
module adc_queue_sequencer (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire ext_trig1,
  input wire ext_trig2,
  input wire debug_halt,
  output reg conv_start,
  output reg conv_abort,
  output reg [5:0] conv_channel,
  output reg [1:0] conv_sample_time,
  input wire conv_done,
  input wire [9:0] conv_result,
  output reg converter_power,
  output wire irq_q1,
  output wire irq_q2
);
  `include "adc_seq_defs.vh"

  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_HALT = 3'b100;

  reg [9:0] ccw_mem [0:63];
  reg [9:0] res_mem [0:63];

  reg [2:0] state_reg;
  reg [1:0] mode1_reg, mode2_reg;
  reg iec1_reg, iep1_reg, iec2_reg, iep2_reg, resume_reg;
  reg [6:0] base2_reg;
  reg stop_reg, frz_en_reg;
  reg cf1_reg, pf1_reg, cf2_reg, pf2_reg;
  reg q1_act_reg, q1_pau_reg, q2_act_reg, q2_pau_reg;
  reg [6:0] ptr1_reg, ptr2_reg, sub2_reg;
  reg [5:0] done1_reg, done2_reg, conv_ptr_reg;
  reg cur_q2_reg;
  reg ext1_d_reg, ext2_d_reg;

  function end_of_queue;
    input [6:0] p;
    input is_q1;
    input [6:0] base;
    input [5:0] chan;
    begin
      end_of_queue = (p >= `TBL_END) || (is_q1 && p >= base) ||
                     (chan == `CH_EOQ); // [R16]
    end
  endfunction

  function [1:0] qstate;
    input act;
    input pau;
    input sus;
    begin
      if (!act)
        qstate = `QS_OFF;
      else if (pau)
        qstate = `QS_PAU;
      else if (sus)
        qstate = `QS_SUS;
      else
        qstate = `QS_ACT;
    end
  endfunction

  wire wr = psel & penable & pwrite;
  wire setup = psel & ~penable;
  wire [3:0] region = paddr[11:8];
  wire [5:0] idx = paddr[7:2];
  wire ctrl_hit = (region == `RG_CTRL) && (paddr[7:4] == 4'h0);
  wire mapped = ctrl_hit || (region >= `RG_CCW && region <= `RG_LEFT);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  wire wr_c1 = wr && paddr == `A_CTRL1;
  wire wr_c2 = wr && paddr == `A_CTRL2;
  wire wr_mcr = wr && paddr == `A_MCR;
  wire wr_st = wr && paddr == `A_STAT;
  wire [1:0] new_mode = pwdata[1:0];
  wire chg1 = wr_c1 && new_mode != mode1_reg;
  wire chg2 = wr_c2 && new_mode != mode2_reg;
  wire go = pwdata[`B_GO] && (new_mode == `M_SW || new_mode == `M_CONT);
  wire trig1 = !stop_reg && ((wr_c1 && go) ||
               (mode1_reg == `M_EXT && ext_trig1 && !ext1_d_reg));
  wire trig2 = !stop_reg && ((wr_c2 && go) ||
               (mode2_reg == `M_EXT && ext_trig2 && !ext2_d_reg));
  wire busy = state_reg == ST_CONV;
  wire abort1 = busy && !cur_q2_reg && chg1; // [R4] [R5]
  wire abort2 = busy && cur_q2_reg && (chg2 || trig1); // [R2] [R4] [R5]
  wire abort_any = abort1 || abort2 || (busy && stop_reg);
  wire res_we = busy && conv_done && !abort_any; // [R20]
  wire frozen = frz_en_reg && debug_halt;

  wire run1 = q1_act_reg && !q1_pau_reg;
  wire run2 = q2_act_reg && !q2_pau_reg && !run1;
  wire [6:0] sel_ptr = run1 ? ptr1_reg : ptr2_reg;
  wire [9:0] sel_ccw = ccw_mem[sel_ptr[5:0]];
  wire sel_end = end_of_queue(sel_ptr, run1, base2_reg, sel_ccw[5:0]);
  wire [9:0] cur_ccw = ccw_mem[conv_ptr_reg];
  // Idle queues show the last converted entry, so done pointers match
  wire [6:0] live_ptr = q1_act_reg ? ptr1_reg :
                        q2_act_reg ? ptr2_reg : {1'b0, conv_ptr_reg}; // [R13]
  wire [3:0] queue_state_field = {qstate(q1_act_reg, q1_pau_reg, 1'b0),
    qstate(q2_act_reg, q2_pau_reg, run1)}; // [R15]

  assign irq_q1 = (cf1_reg & iec1_reg) | (pf1_reg & iep1_reg); // [R1] [R17]
  assign irq_q2 = (cf2_reg & iec2_reg) | (pf2_reg & iep2_reg); // [R1] [R17]

  wire [15:0] aligned;
  reg [1:0] fmt;
  always @* begin
    case (region)
      `RG_SIGNED: fmt = `F_SIGNED;
      `RG_LEFT: fmt = `F_LEFT;
      default: fmt = `F_RIGHT;
    endcase
  end

  result_align u_align (
    .raw(res_mem[idx]), // [R19]
    .fmt(fmt),
    .aligned(aligned)
  );

  // Tables are plain RAM, left unreset
  always @(posedge pclk) begin
    if (wr && region == `RG_CCW)
      ccw_mem[idx] <= pwdata[9:0]; // [R18]
    if (res_we)
      res_mem[conv_ptr_reg] <= conv_result; // [R8]
    else if (wr && region >= `RG_RIGHT && region <= `RG_LEFT)
      res_mem[idx] <= pwdata[9:0]; // [R12] [R9]
  end

  // Read data is captured in the setup cycle so it comes from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup) begin
      case (region)
        `RG_CCW: prdata <= {22'h00_0000, ccw_mem[idx]};
        `RG_RIGHT, `RG_SIGNED, `RG_LEFT: prdata <= {16'h0000, aligned};
        `RG_CTRL: begin
          case (paddr)
            `A_CTRL1: prdata <= {26'h0, 1'b0, 1'b0, iep1_reg,
                                 iec1_reg, mode1_reg};
            `A_CTRL2: prdata <= {17'h0, base2_reg, 2'h0, resume_reg,
                                 1'b0, iep2_reg, iec2_reg, mode2_reg};
            `A_MCR: prdata <= {30'h0, frz_en_reg, stop_reg};
            `A_STAT: prdata <= {2'h0, done2_reg, 2'h0, done1_reg,
                                1'b0, live_ptr, queue_state_field,
                                pf2_reg, cf2_reg, pf1_reg, cf1_reg};
            default: prdata <= 32'h0000_0000;
          endcase
        end
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      mode1_reg <= `M_DIS;
      mode2_reg <= `M_DIS;
      {iec1_reg, iep1_reg, iec2_reg, iep2_reg, resume_reg} <= 5'h00;
      base2_reg <= `TBL_END;
      stop_reg <= 1'b0;
      frz_en_reg <= 1'b0;
      {cf1_reg, pf1_reg, cf2_reg, pf2_reg} <= 4'h0;
      {q1_act_reg, q1_pau_reg, q2_act_reg, q2_pau_reg} <= 4'h0;
      ptr1_reg <= 7'h00;
      ptr2_reg <= 7'h00;
      sub2_reg <= 7'h00;
      done1_reg <= 6'h00;
      done2_reg <= 6'h00;
      conv_ptr_reg <= 6'h00;
      cur_q2_reg <= 1'b0;
      ext1_d_reg <= 1'b0;
      ext2_d_reg <= 1'b0;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      conv_channel <= 6'h00;
      conv_sample_time <= 2'h0;
      converter_power <= 1'b1;
    end else begin
      conv_start <= 1'b0;
      conv_abort <= abort_any; // [R2] [R4] [R5] [R6]
      ext1_d_reg <= ext_trig1;
      ext2_d_reg <= ext_trig2;
      converter_power <= !stop_reg; // [R4] [R6]

      if (wr_c1) begin
        mode1_reg <= new_mode;
        {iep1_reg, iec1_reg} <= pwdata[`B_IEP:`B_IEC];
      end
      if (wr_c2) begin
        mode2_reg <= new_mode;
        {iep2_reg, iec2_reg} <= pwdata[`B_IEP:`B_IEC];
        resume_reg <= pwdata[`B_RESUME];
        base2_reg <= pwdata[14:8];
      end
      if (wr_mcr) begin
        stop_reg <= pwdata[`B_STOP];
        frz_en_reg <= pwdata[`B_FRZ];
      end
      // Write one to clear; any set further down overrides
      if (wr_st) begin
        cf1_reg <= cf1_reg & ~pwdata[0];
        pf1_reg <= pf1_reg & ~pwdata[1];
        cf2_reg <= cf2_reg & ~pwdata[2];
        pf2_reg <= pf2_reg & ~pwdata[3];
      end

      // Mode change drops the queue back to its first entry; a go bit
      // in the same write is the trigger that starts it again
      if (chg1) begin
        q1_act_reg <= trig1; // [R5]
        q1_pau_reg <= 1'b0;
        ptr1_reg <= 7'h00;
      end else if (trig1) begin
        q1_act_reg <= 1'b1;
        q1_pau_reg <= 1'b0;
        if (q1_pau_reg)
          ptr1_reg <= ptr1_reg + 7'h01; // [R14]
        else if (!q1_act_reg)
          ptr1_reg <= 7'h00;
      end

      if (chg2) begin
        q2_act_reg <= trig2; // [R5]
        q2_pau_reg <= 1'b0;
        ptr2_reg <= wr_c2 ? pwdata[14:8] : base2_reg;
        sub2_reg <= wr_c2 ? pwdata[14:8] : base2_reg;
      end else if (trig2) begin
        q2_act_reg <= 1'b1;
        q2_pau_reg <= 1'b0;
        if (q2_pau_reg) begin
          ptr2_reg <= ptr2_reg + 7'h01; // [R14]
          sub2_reg <= ptr2_reg + 7'h01;
        end else if (!q2_act_reg) begin
          ptr2_reg <= base2_reg;
          sub2_reg <= base2_reg;
        end
      end else if (trig1 && q2_act_reg && !q2_pau_reg && !resume_reg &&
                   !(res_we && cur_q2_reg))
        ptr2_reg <= sub2_reg; // [R3]

      case (state_reg)
        ST_IDLE: begin
          if (stop_reg) begin
            state_reg <= ST_IDLE;
          end else if (frozen) begin
            state_reg <= ST_HALT; // [R7]
          end else if ((run1 && !chg1 && !trig1) ||
                       (run2 && !chg2 && !trig1)) begin
            if (sel_end) begin
              if (run1) begin
                cf1_reg <= 1'b1; // [R1]
                ptr1_reg <= 7'h00;
                q1_act_reg <= mode1_reg == `M_CONT;
              end else begin
                cf2_reg <= 1'b1; // [R1]
                ptr2_reg <= base2_reg;
                sub2_reg <= base2_reg;
                q2_act_reg <= mode2_reg == `M_CONT;
              end
            end else begin
              conv_start <= 1'b1;
              conv_channel <= sel_ccw[5:0];
              conv_sample_time <= sel_ccw[7:6];
              conv_ptr_reg <= sel_ptr[5:0];
              cur_q2_reg <= !run1;
              state_reg <= ST_CONV;
            end
          end
        end
        ST_CONV: begin
          if (abort_any) begin
            state_reg <= ST_IDLE; // [R20]
          end else if (conv_done) begin
            state_reg <= frozen ? ST_HALT : ST_IDLE; // [R7]
            if (!cur_q2_reg) begin
              done1_reg <= conv_ptr_reg; // [R13]
              if (cur_ccw[9]) begin
                q1_pau_reg <= 1'b1; // [R17]
                pf1_reg <= 1'b1;
              end else if (!trig1) begin
                ptr1_reg <= ptr1_reg + 7'h01; // [R14]
              end
            end else begin
              done2_reg <= conv_ptr_reg; // [R13]
              if (cur_ccw[9]) begin
                q2_pau_reg <= 1'b1; // [R17]
                pf2_reg <= 1'b1;
              end else if (!trig2) begin
                ptr2_reg <= ptr2_reg + 7'h01; // [R14]
              end
            end
          end
        end
        ST_HALT: begin
          if (!frozen || stop_reg)
            state_reg <= ST_IDLE; // [R7]
        end
        default: state_reg <= ST_IDLE;
      endcase

      // Stop clears both queue mode fields and idles the queues
      if (stop_reg) begin
        mode1_reg <= `M_DIS; // [R6]
        mode2_reg <= `M_DIS;
        {q1_act_reg, q1_pau_reg, q2_act_reg, q2_pau_reg} <= 4'h0;
        ptr1_reg <= 7'h00;
        ptr2_reg <= base2_reg;
        sub2_reg <= base2_reg;
      end
    end
  end
endmodule

// File: bench/conv_model.sv
// Behavioural converter answering the sequencer's start requests
module conv_model (
  input wire pclk,
  input wire presetn,
  input wire conv_start,
  input wire conv_abort,
  input wire [5:0] conv_channel,
  input wire [7:0] lat,
  output reg conv_done,
  output reg [9:0] conv_result
);
  timeunit 1ns;
  timeprecision 1ns;
  reg busy;
  reg [7:0] cnt;
  reg [5:0] ch;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      ch <= 6'h00;
      conv_done <= 1'b0;
      conv_result <= 10'h000;
    end else begin
      conv_done <= 1'b0;
      // Garbage between answers so a stale value never passes
      conv_result <= ~conv_result;
      if (conv_start) begin
        busy <= 1'b1;
        cnt <= lat;
        ch <= conv_channel;
      end else if (conv_abort) begin
        busy <= 1'b0;
      end else if (busy && cnt == 8'h00) begin
        busy <= 1'b0;
        conv_done <= 1'b1;
        conv_result <= {ch, 4'h9};
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule

// File: bench/seq_sva.sv
// Port checker for the queue sequencer
module seq_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pslverr,
  input wire conv_start,
  input wire conv_abort,
  input wire [5:0] conv_channel,
  input wire conv_done,
  input wire converter_power,
  input wire irq_q1
);
  timeunit 1ns;
  timeprecision 1ns;
  reg busy;
  wire wr = psel & penable & pwrite;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      busy <= 1'b0;
    else if (conv_start)
      busy <= 1'b1;
    else if (conv_done | conv_abort)
      busy <= 1'b0;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence stop_wr;
    wr && paddr == 12'h008 && pwdata[0];
  endsequence
  sequence off_wr;
    wr && paddr == 12'h000 && pwdata[1:0] == 2'h0;
  endsequence
  a_stop_abort: assert property (busy && !conv_done ##0 stop_wr
    |-> ##[1:3] conv_abort) else $error("stop left conversion running");
  a_off_abort: assert property (busy && !conv_done ##0 off_wr
    |-> ##[1:3] conv_abort) else $error("disable left conversion running");
  a_power_kept: assert property (off_wr ##0 converter_power
    |=> converter_power [*2]) else $error("disable powered down");
  a_stop_power: assert property (stop_wr |-> ##[1:2] !converter_power)
    else $error("stop kept converter powered");
  a_abort_busy: assert property (conv_abort |-> busy)
    else $error("abort without conversion");
  a_start_idle: assert property (conv_start |-> !busy || conv_abort)
    else $error("start while conversion outstanding");
  a_start_gap: assert property (conv_done |=> !conv_start)
    else $error("start right after done");
  a_chan_hold: assert property (busy && !conv_start |-> $stable(conv_channel))
    else $error("channel moved mid conversion");
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  a_irq_fall: assert property ($fell(irq_q1) |-> $past(wr))
    else $error("interrupt dropped without write");
endmodule
bind adc_queue_sequencer seq_sva chk (.*);

// File: bench/adc_queue_sequencer_results_test.sv
// Directed APB bench for the queue sequencer and result table
module adc_queue_sequencer_results_test;
  timeunit 1ns;
  timeprecision 1ns;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  reg pwrite = 1'b0, perr, dbg = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, q;
  reg [7:0] lat = 8'h02;
  wire [31:0] prdata;
  wire pready, pslverr, conv_start, conv_abort, conv_done;
  wire converter_power, irq_q1;
  wire [5:0] conv_channel;
  wire [9:0] conv_result;
  integer n_fail = 0, compares = 0, cyc = 0, i;
  always #10 pclk = ~pclk;
  adc_queue_sequencer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_trig1(1'b0),
    .ext_trig2(1'b0), .debug_halt(dbg), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_channel(conv_channel),
    .conv_sample_time(), .conv_done(conv_done), .conv_result(conv_result),
    .converter_power(converter_power), .irq_q1(irq_q1), .irq_q2());
  conv_model cm (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_channel(conv_channel), .lat(lat),
    .conv_done(conv_done), .conv_result(conv_result));
  task chk(input [31:0] s, input [31:0] e);
    begin
      compares = compares + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] m, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(q & m, e);
    end
  endtask
  task wait_irq;
    begin
      i = 0;
      while (irq_q1 !== 1'b1 && i < 400) begin
        @(posedge pclk);
        i = i + 1;
      end
      chk({31'h0, irq_q1}, 32'h1);
    end
  endtask
  task fmt(input [11:0] o);
    begin
      apb(1'b1, 12'h200 | o, 32'hfffff2a5);
      rd(12'h200 | o, 32'hffffffff, 32'h2a5);
      rd(12'h300 | o, 32'hffffffff, 32'h2940);
      rd(12'h400 | o, 32'hffffffff, 32'ha940);
      apb(1'b1, 12'h400 | o, 32'h1c3);
      rd(12'h200 | o, 32'hffffffff, 32'h1c3);
    end
  endtask
  task conclude;
    begin
      $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Whole run needs under a thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      conclude;
    end
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h00c, 32'hff, 32'h0);
    rd(12'h0f0, 32'hffffffff, 32'h0);
    chk({31'h0, perr}, 32'h1);
    apb(1'b1, 12'h100, 32'hffffffff);
    rd(12'h100, 32'hffffffff, 32'h3ff);
    fmt(12'h000);
    fmt(12'h0fc);
    $display("test tables done");
    apb(1'b1, 12'h100, 32'h003);
    apb(1'b1, 12'h104, 32'h005);
    apb(1'b1, 12'h108, 32'h03f);
    apb(1'b1, 12'h004, 32'h4000);
    apb(1'b1, 12'h000, 32'h15);
    wait_irq;
    rd(12'h200, 32'hffffffff, 32'h039);
    rd(12'h204, 32'hffffffff, 32'h059);
    rd(12'h00c, 32'hff, 32'h01);
    chk({25'h0, q[14:8]}, {26'h0, q[21:16]});
    apb(1'b1, 12'h00c, 32'h1);
    @(posedge pclk);
    chk({31'h0, irq_q1}, 32'h0);
    $display("test scan done");
    apb(1'b1, 12'h100, 32'h203);
    apb(1'b1, 12'h204, 32'h0);
    apb(1'b1, 12'h000, 32'h19);
    wait_irq;
    rd(12'h00c, 32'h7ff2, 32'h0042);
    apb(1'b1, 12'h00c, 32'h2);
    lat <= 8'h28;
    apb(1'b1, 12'h000, 32'h1d);
    rd(12'h00c, 32'hf0, 32'h80);
    wait_irq;
    rd(12'h204, 32'hffffffff, 32'h059);
    apb(1'b1, 12'h00c, 32'h3);
    $display("test pause done");
    apb(1'b1, 12'h100, 32'h003);
    apb(1'b1, 12'h200, 32'h155);
    apb(1'b1, 12'h000, 32'h11);
    repeat (5) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h0);
    repeat (60) @(posedge pclk);
    rd(12'h200, 32'hffffffff, 32'h155);
    chk({31'h0, converter_power}, 32'h1);
    apb(1'b1, 12'h000, 32'h11);
    repeat (5) @(posedge pclk);
    apb(1'b1, 12'h008, 32'h1);
    repeat (60) @(posedge pclk);
    rd(12'h200, 32'hffffffff, 32'h155);
    chk({31'h0, converter_power}, 32'h0);
    apb(1'b1, 12'h008, 32'h0);
    $display("test abort done");
    apb(1'b1, 12'h204, 32'h0);
    apb(1'b1, 12'h008, 32'h2);
    apb(1'b1, 12'h000, 32'h15);
    repeat (5) @(posedge pclk);
    dbg <= 1'b1;
    repeat (100) @(posedge pclk);
    rd(12'h200, 32'hffffffff, 32'h039);
    rd(12'h204, 32'hffffffff, 32'h0);
    dbg <= 1'b0;
    wait_irq;
    rd(12'h204, 32'hffffffff, 32'h059);
    apb(1'b1, 12'h00c, 32'h3);
    apb(1'b1, 12'h008, 32'h0);
    $display("test freeze done");
    conclude;
  end
endmodule
